// >>> hdl/rpic_regs.svh
// Constants for the reset, power-down and interrupt pin control block.
// Assumes a single 10 MHz core clock.
`ifndef RPIC_REGS_SVH
`define RPIC_REGS_SVH
`define RPIC_CLK_MHZ        10
`define RPIC_RST_MIN_NS     1000
`define RPIC_RST_MIN_CYC    ((`RPIC_RST_MIN_NS * `RPIC_CLK_MHZ + 999) / 1000)
`define RPIC_STRAP_W        8
`define RPIC_STRAP_DFLT     8'h01
`define RPIC_IRQ_W          4
`endif

// >>> hdl/rpic_pkg.sv
// Types for the reset, power-down and interrupt pin control block.
// Assumes the constants header is compiled alongside.
`include "rpic_regs.svh"
package rpic_pkg;
    typedef enum logic [2:0] {
        RPIC_ST_RESET = 3'b001,
        RPIC_ST_RUN   = 3'b010,
        RPIC_ST_SLEEP = 3'b100
    } rpic_state_type;

    typedef struct packed {
        logic       drive_low;
        logic       oe_n;
    } rpic_pin_out_type;

    typedef struct packed {
        logic       wr;
        logic       sleep_pin_is_irq;
        logic [`RPIC_IRQ_W-1:0] irq_clear;
    } rpic_cfg_type;
endpackage

// >>> hdl/rpic_ctrl.sv
// Reset, power-down / interrupt pin and test reset control.
// Assumes pins arrive asynchronous; management writes arrive on clk_i.
//
// Notes on behaviour
// - Reset pin low at least 1 us runs a full reset, active low.
// - Hardware reset returns pin role, pending bits and strap config to defaults.
// - Hardware reset also reloads strap-derived configuration.
// - After reset the shared pin is a power-down input.
// - Shared pin low in power-down role puts device to sleep.
// - Management access stays live during sleep.
// - Configuration can switch the shared pin to interrupt output.
// - In interrupt role a pending interrupt drives the pin low.
// - Test logic is held in reset while test reset is low.
// - Software reset restores straps captured at hardware reset.
`timescale 1ns/100ps
`include "rpic_regs.svh"
module rpic_ctrl
    import rpic_pkg::*;
#(
    parameter int RST_MIN_CYC = `RPIC_RST_MIN_CYC
) (
    input  wire logic                    clk_i,
    input  wire logic                    rst_n_i,
    input  wire logic                    hw_reset_n_i,
    input  wire logic                    sleep_or_irq_pin_i,
    input  wire logic                    test_reset_n_i,
    input  wire logic [`RPIC_STRAP_W-1:0] strap_pins_i,
    input  wire logic                    sw_reset_i,
    input  wire rpic_cfg_type            cfg_i,
    input  wire logic [`RPIC_IRQ_W-1:0]   irq_event_i,
    output logic                         core_reset_o,
    output logic                         sleep_o,
    output logic                         test_reset_o,
    output logic [`RPIC_STRAP_W-1:0]      strap_cfg_o,
    output logic                         pin_is_irq_o,
    output rpic_pin_out_type             pin_o,
    output logic [`RPIC_IRQ_W-1:0]        irq_pending_o
);
    // Three-stage synchronisers; stage 1 feeds only stage 2
    logic [2:0] rst_s_q, slp_s_q, trst_s_q;
    logic [2:0] rst_s_d, slp_s_d, trst_s_d;
    logic       rst_lvl_q, slp_lvl_q, trst_lvl_q;
    logic       rst_lvl_d, slp_lvl_d, trst_lvl_d;

    always_comb begin
        rst_s_d  = {rst_s_q[1:0], hw_reset_n_i};
        slp_s_d  = {slp_s_q[1:0], sleep_or_irq_pin_i};
        trst_s_d = {trst_s_q[1:0], test_reset_n_i};
        rst_lvl_d  = (rst_s_q[1] == rst_s_q[2]) ? rst_s_q[2] : rst_lvl_q;
        slp_lvl_d  = (slp_s_q[1] == slp_s_q[2]) ? slp_s_q[2] : slp_lvl_q;
        trst_lvl_d = (trst_s_q[1] == trst_s_q[2]) ? trst_s_q[2]
                                                   : trst_lvl_q;
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rst_s_q    <= 3'h7;
            slp_s_q    <= 3'h7;
            trst_s_q   <= 3'h7;
            rst_lvl_q  <= 1'h1;
            slp_lvl_q  <= 1'h1;
            trst_lvl_q <= 1'h1;
        end else begin
            rst_s_q    <= rst_s_d;
            slp_s_q    <= slp_s_d;
            trst_s_q   <= trst_s_d;
            rst_lvl_q  <= rst_lvl_d;
            slp_lvl_q  <= slp_lvl_d;
            trst_lvl_q <= trst_lvl_d;
        end
    end

    // Low-time counter; a reset only counts once it lasted the minimum
    localparam int CW = $clog2(RST_MIN_CYC + 1);
    logic [CW-1:0]    low_cnt_q, low_cnt_d;
    rpic_state_type   st_q, st_d;
    logic             core_rst_q, core_rst_d;
    logic             hw_rst_ev;

    always_comb begin
        low_cnt_d = low_cnt_q;
        if (rst_lvl_q) begin
            low_cnt_d = '0;
        end else if (low_cnt_q < CW'(RST_MIN_CYC)) begin
            low_cnt_d = low_cnt_q + CW'(1);
        end
        // Pulse shorter than the minimum never reaches the count
        hw_rst_ev = !rst_lvl_q && (low_cnt_q >= CW'(RST_MIN_CYC));
    end

    // Shared pin role and strap image
    logic                     is_irq_q, is_irq_d;
    logic [`RPIC_STRAP_W-1:0] strap_lat_q, strap_lat_d;
    logic [`RPIC_STRAP_W-1:0] strap_cfg_q, strap_cfg_d;
    logic [`RPIC_IRQ_W-1:0]   pend_q, pend_d;
    logic                     sleep_q, sleep_d;
    logic                     pin_low_q, pin_low_d;
    logic                     pin_oe_n_q, pin_oe_n_d;
    logic                     trst_q, trst_d;

    always_comb begin
        st_d        = st_q;
        core_rst_d  = 1'h0;
        is_irq_d    = is_irq_q;
        strap_lat_d = strap_lat_q;
        strap_cfg_d = strap_cfg_q;
        pend_d      = pend_q;
        unique case (st_q)
            RPIC_ST_RESET: begin
                // Straps sampled once the pin is released
                core_rst_d  = 1'h1;
                if (rst_lvl_q) begin
                    strap_lat_d = strap_pins_i;
                    strap_cfg_d = strap_pins_i;
                    st_d        = RPIC_ST_RUN;
                end
            end
            RPIC_ST_RUN, RPIC_ST_SLEEP: begin
                // Config writes still taken while asleep
                if (cfg_i.wr) begin
                    is_irq_d = cfg_i.sleep_pin_is_irq;
                end
                // Set wins over clear
                pend_d = (pend_q & ~cfg_i.irq_clear) | irq_event_i;
                if (sw_reset_i) begin
                    strap_cfg_d = strap_lat_q;
                    is_irq_d    = 1'h0;
                    pend_d      = irq_event_i;
                end
                st_d = (!is_irq_q && !slp_lvl_q) ? RPIC_ST_SLEEP
                                                 : RPIC_ST_RUN;
            end
            default: st_d = RPIC_ST_RESET;
        endcase
        if (hw_rst_ev) begin
            st_d        = RPIC_ST_RESET;
            core_rst_d  = 1'h1;
            is_irq_d    = 1'h0;
            pend_d      = '0;
            strap_cfg_d = `RPIC_STRAP_DFLT;
        end
        sleep_d    = (st_d == RPIC_ST_SLEEP);
        pin_low_d  = is_irq_d && (pend_d != '0);
        pin_oe_n_d = !pin_low_d;
        trst_d     = !trst_lvl_q;
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            low_cnt_q   <= '0;
            st_q        <= RPIC_ST_RESET;
            core_rst_q  <= 1'h1;
            is_irq_q    <= 1'h0;
            strap_lat_q <= `RPIC_STRAP_DFLT;
            strap_cfg_q <= `RPIC_STRAP_DFLT;
            pend_q      <= '0;
            sleep_q     <= 1'h0;
            pin_low_q   <= 1'h0;
            pin_oe_n_q  <= 1'h1;
            trst_q      <= 1'h1;
        end else begin
            low_cnt_q   <= low_cnt_d;
            st_q        <= st_d;
            core_rst_q  <= core_rst_d;
            is_irq_q    <= is_irq_d;
            strap_lat_q <= strap_lat_d;
            strap_cfg_q <= strap_cfg_d;
            pend_q      <= pend_d;
            sleep_q     <= sleep_d;
            pin_low_q   <= pin_low_d;
            pin_oe_n_q  <= pin_oe_n_d;
            trst_q      <= trst_d;
        end
    end

    assign core_reset_o      = core_rst_q;
    assign sleep_o           = sleep_q;
    assign test_reset_o      = trst_q;
    assign strap_cfg_o       = strap_cfg_q;
    assign pin_is_irq_o      = is_irq_q;
    assign pin_o.drive_low   = pin_low_q;
    assign pin_o.oe_n        = pin_oe_n_q;
    assign irq_pending_o     = pend_q;

    a_short_rst_ignored: assert property (
        @(posedge clk_i) disable iff (!rst_n_i)
        (st_q != RPIC_ST_RESET && rst_lvl_q && !rst_lvl_d)
        ##1 !rst_lvl_q [*2] ##1 rst_lvl_q
        |-> !core_rst_q)
        else $error("short reset pulse caused reset");
    a_pend_sticky: assert property (
        @(posedge clk_i) disable iff (!rst_n_i)
        (st_q != RPIC_ST_RESET && !hw_rst_ev && !sw_reset_i)
        |=> (pend_q & (($past(pend_q) & ~$past(cfg_i.irq_clear))
                       | $past(irq_event_i)))
            == (($past(pend_q) & ~$past(cfg_i.irq_clear))
                | $past(irq_event_i)))
        else $error("pending bit lost without clear");
    a_long_rst_acts: assert property (
        @(posedge clk_i) disable iff (!rst_n_i)
        hw_rst_ev |=> core_rst_q && st_q == RPIC_ST_RESET)
        else $error("qualified reset did not reset core");
    a_rst_clears_regs: assert property (
        @(posedge clk_i) disable iff (!rst_n_i)
        hw_rst_ev |=> pend_q == '0 && !is_irq_q)
        else $error("registers not at default after reset");
    a_strap_reload: assert property (
        @(posedge clk_i) disable iff (!rst_n_i)
        (st_q == RPIC_ST_RESET && rst_lvl_q && !hw_rst_ev)
        |=> strap_lat_q == $past(strap_pins_i))
        else $error("straps not sampled at reset release");
    a_sw_strap_restore: assert property (
        @(posedge clk_i) disable iff (!rst_n_i)
        (sw_reset_i && st_q != RPIC_ST_RESET && !hw_rst_ev)
        |=> strap_cfg_q == $past(strap_lat_q))
        else $error("soft reset did not restore straps");
    a_sleep_entry: assert property (
        @(posedge clk_i) disable iff (!rst_n_i)
        (st_q == RPIC_ST_RUN && !is_irq_q && !slp_lvl_q && !hw_rst_ev)
        |=> sleep_q)
        else $error("power-down request not honoured");
    a_irq_pin_low: assert property (
        @(posedge clk_i) disable iff (!rst_n_i)
        (is_irq_q && pend_q != '0) |-> pin_low_q && !pin_oe_n_q)
        else $error("pending interrupt not driven low");
    a_pin_input_role: assert property (
        @(posedge clk_i) disable iff (!rst_n_i)
        !is_irq_q |-> pin_oe_n_q)
        else $error("pin driven while in power-down role");
    a_cfg_in_sleep: assert property (
        @(posedge clk_i) disable iff (!rst_n_i)
        (sleep_q && cfg_i.wr && !sw_reset_i && !hw_rst_ev)
        |=> is_irq_q == $past(cfg_i.sleep_pin_is_irq))
        else $error("config write lost during sleep");
    a_test_reset: assert property (
        @(posedge clk_i) disable iff (!rst_n_i)
        !trst_lvl_q |=> test_reset_o)
        else $error("test reset not applied");
endmodule

// >>> dv/rpic_host_model.sv
// Host side of the shared sleep / interrupt pin, with its pull-up.
// Assumes the bench supplies the host's request to pull the pin low.
`timescale 1ns/100ps
module rpic_host_model
    import rpic_pkg::*;
(
    input  wire logic             host_low_i,
    input  wire rpic_pin_out_type pin_i,
    output logic                  level_o
);
    // Wired low: either party may pull, the pull-up wins otherwise
    assign level_o = !(host_low_i || (!pin_i.oe_n && pin_i.drive_low));
endmodule

// >>> dv/rpic_ctrl_bench.sv
// Self-checking bench for the reset, sleep and interrupt pin control.
// Assumes the design package and the host model are compiled first.
`timescale 1ns/100ps
module rpic_ctrl_bench
    import rpic_pkg::*;
;
    typedef struct {
        string       nm;
        logic [17:0] m;
        logic [17:0] e;
    } rpic_note_type;
    localparam logic [17:0] A = 18'h3ffff;
    localparam logic [17:0] C = 18'h20000;
    localparam logic [17:0] S = 18'h10000;
    localparam logic [17:0] T = 18'h08000;
    localparam logic [17:0] PIN = 18'h07f00;
    logic             clk_i = 1'b0;
    logic             rst_n_i = 1'b0;
    logic             hw_n = 1'b1;
    logic             host_low = 1'b0;
    logic             trst_n = 1'b1;
    logic             swr = 1'b0;
    logic       [7:0] straps = 8'h00;
    logic       [3:0] ev = 4'h0;
    rpic_cfg_type     cfg = '0;
    logic             lvl, core_rst, slp, trst_o, role;
    rpic_pin_out_type pin;
    logic       [3:0] pend;
    logic       [7:0] scfg;
    wire       [17:0] obs = {core_rst, slp, trst_o, role, pin, pend, scfg};
    rpic_note_type    q[$];
    event             look;
    int               n_fail = 0;
    int               checks_done = 0;
    int               cyc = 0;

    rpic_ctrl #(.RST_MIN_CYC(4)) uut (.clk_i(clk_i), .rst_n_i(rst_n_i),
        .hw_reset_n_i(hw_n), .sleep_or_irq_pin_i(lvl),
        .test_reset_n_i(trst_n), .strap_pins_i(straps), .sw_reset_i(swr),
        .cfg_i(cfg), .irq_event_i(ev), .core_reset_o(core_rst),
        .sleep_o(slp), .test_reset_o(trst_o), .strap_cfg_o(scfg),
        .pin_is_irq_o(role), .pin_o(pin), .irq_pending_o(pend));
    rpic_host_model host (.host_low_i(host_low), .pin_i(pin),
        .level_o(lvl));

    always #50 clk_i = ~clk_i;

    task conclude();
        if (n_fail == 0 && checks_done > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    // Ceiling well above the roughly 90 cycles the sequence needs
    always @(posedge clk_i) begin
        cyc++;
        if (cyc == 3000) begin
            n_fail++;
            conclude();
        end
    end

    task tick(input int n);
        repeat (n) @(posedge clk_i);
        #10;
    endtask

    task chk(input string nm, input logic [17:0] m, input logic [17:0] e);
        q.push_back('{nm, m, e});
        -> look;
    endtask

    task cmp(input rpic_note_type w);
        checks_done++;
        if ((obs & w.m) !== (w.e & w.m)) begin
            n_fail++;
            $display("CHECK FAILED %s expected %h seen %h",
                     w.nm, w.e & w.m, obs & w.m);
        end
    endtask

    always @(look) while (q.size() > 0) cmp(q.pop_front());

    task role_wr(input logic irq);
        cfg.wr = 1'b1;
        cfg.sleep_pin_is_irq = irq;
        tick(1);
        cfg.wr = 1'b0;
        tick(1);
    endtask

    initial begin
        logic [7:0] s0, s1;
        logic [3:0] e, keep;
        void'($urandom(32'hf8b12445));
        s0 = 8'($urandom());
        s1 = ~s0;
        straps = s0;
        tick(10);
        rst_n_i = 1'b1;
        tick(8);
        chk("reset exit", A, {10'h010, s0});
        trst_n = 1'b0;
        tick(5);
        chk("test reset on", T, T);
        trst_n = 1'b1;
        tick(5);
        chk("test reset off", T, 18'h0);
        role_wr(1'b1);
        e = 4'($urandom_range(15, 1));
        keep = e & (~e + 4'h1);
        ev = e;
        tick(1);
        ev = 4'h0;
        tick(5);
        // Device pulls its own pin low, yet it must not fall asleep
        chk("irq pin low", S | PIN, {6'b000110, e, 8'h00});
        cfg.irq_clear = e ^ keep;
        tick(1);
        cfg.irq_clear = 4'h0;
        tick(1);
        chk("irq partial clear", PIN, {6'b000110, keep, 8'h00});
        cfg.irq_clear = keep;
        tick(1);
        cfg.irq_clear = 4'h0;
        tick(1);
        chk("irq all clear", PIN, {6'b000101, 4'h0, 8'h00});
        role_wr(1'b0);
        host_low = 1'b1;
        tick(8);
        chk("sleep entry", S, S);
        role_wr(1'b1);
        chk("role write asleep", 18'h04000, 18'h04000);
        host_low = 1'b0;
        straps = s1;
        swr = 1'b1;
        tick(1);
        swr = 1'b0;
        tick(3);
        chk("soft reset", PIN | 18'hff, {6'b000001, 4'h0, s0});
        // Two low samples pass the filter but stay under the minimum
        hw_n = 1'b0;
        tick(2);
        hw_n = 1'b1;
        tick(8);
        chk("short reset pulse", C | 18'hff, {10'h0, s0});
        role_wr(1'b1);
        ev = 4'h8;
        tick(1);
        ev = 4'h0;
        hw_n = 1'b0;
        tick(10);
        chk("hw reset held", C, C);
        hw_n = 1'b1;
        tick(10);
        chk("hw reset done", A, {10'h010, s1});
        tick(2);
        conclude();
    end
endmodule
